// ===== hdl/cisc_pkg.sv
// Shared constants of the contact image scan controller.
package cisc_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte offsets) and fields.
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_CFG       = 8'h00;
  localparam logic [7:0] OFF_LINE_SEL  = 8'h04;
  localparam logic [7:0] OFF_CH0_CTRL  = 8'h08;
  localparam logic [7:0] OFF_CH2_CTRL  = 8'h0c;
  localparam logic [7:0] OFF_DITHER_LO = 8'h10;
  localparam logic [7:0] OFF_DITHER_HI = 8'h14;
  localparam logic [7:0] OFF_BG_CONST  = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1c;

  localparam int CFG_SCAN_BIT    = 0;
  localparam int CFG_CH0_SEL_BIT = 1;
  localparam int CFG_GRAY_BIT    = 2;
  localparam int CHAN_ON_BIT     = 0;
  localparam int ST_AVW_BIT      = 0;
  localparam int ST_PDW_BIT      = 1;
  localparam int ST_OVR_BIT      = 2;
  localparam int ST_BG_LSB       = 8;
  localparam int ST_LINE_LSB     = 16;

  localparam logic [31:0] DITHER_RST = 32'h80808080;
  localparam logic [7:0]  BG_RST     = 8'hff;

  // ---------------------------------------------------------------------
  // Timing, with mclk at 20 MHz.
  // ---------------------------------------------------------------------
  localparam int MCLK_NS      = 50;
  localparam int LS_MIN_NS    = 1000;
  localparam int DIS_DLY_NS   = 1875;
  localparam int DIS_W_NS     = 625;
  localparam int SEP_NS       = 800;
  localparam int LINE_MIN_NS  = 2500000;
  localparam int LS_CYC       = (LS_MIN_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int DIS_DLY_CYC  = (DIS_DLY_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int DIS_W_CYC    = (DIS_W_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int SEP_CYC      = (SEP_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int LINE_BASE    = LINE_MIN_NS / MCLK_NS;
  // One strobe period is exactly one half of the pixel timing period.
  localparam int HALF_CYC     = DIS_DLY_CYC + DIS_W_CYC;
  localparam int PIX_CYC      = 2 * HALF_CYC;
  localparam int SNH_DLY_CYC  = 32;
  localparam int SNH_W_CYC    = 4;
  localparam int LS_LEAD      = SEP_CYC;
  localparam int PIX_START    = LS_LEAD + LS_CYC + SEP_CYC;

  // ---------------------------------------------------------------------
  // Line geometry in pixels.
  // ---------------------------------------------------------------------
  localparam int PIX_TOTAL    = 1734;
  localparam int PDW_FIRST    = 435;
  localparam int PDW_LEN      = 863;

endpackage : cisc_pkg

// ===== hdl/cisc_scan_ctrl.sv
// Scan controller: sync strobes, correction fetch, dithering and bit packing.
//
// Contract
// [RQ1] Scan-run bit starts all five strobes.
// [RQ2] Line start rate selectable: 400/200/100/50 Hz.
// [RQ3] Channel 0 fetches synced to active window.
// [RQ4] Peak window lies inside active window.
// [RQ5] Select plus enable requests first two bytes.
// [RQ6] Correction byte moved per sample-hold strobe.
// [RQ7] Video plus correction feeds comparator, tracker.
// [RQ8] Threshold from dither byte times background.
// [RQ9] Bi-level: background is peak compensated level.
// [RQ10] Gray-scale: background forced to constant.
// [RQ11] Comparator bit shifted into shift register.
// [RQ12] Full word goes out via channel 2.
// [RQ13] Line start pulse at least 1000 ns.
// [RQ14] Reset strobe delay 1875 ns, width 625 ns.
// [RQ15] Line start edges 800 ns from pixel edges.
// [RQ16] Strobes run at twice pixel timing rate.
// [RQ17] Up to 1728 pixels plus six dummies.
// [RQ18] Clearing scan-run returns strobes inactive.
// [RQ19] Peak window repeats on every line.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module cisc_scan_ctrl #(
  parameter int LINE_BASE_CYC = cisc_pkg::LINE_BASE
) (
  // System clock and reset.
  input  wire logic        mclk,
  input  wire logic        resetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensor and sample-hold strobes.
  output logic             sampleHoldStrobe,
  output logic             outputResetStrobe,
  output logic             lineStartPulse,
  output logic             peakWindow,
  output logic             sensorShiftTiming,
  // Sampled video from the sample-hold converter, on its own clock.
  input  wire logic        linkClk,
  input  wire logic        videoStrobe,
  input  wire logic [7:0]  videoInputLevel,
  // Channel 0: correction fetch, two bytes per request.
  output logic             dma0Req,
  input  wire logic        dma0Ack,
  input  wire logic [15:0] dma0Data,
  // Channel 2: packed bitmap word.
  output logic             dma2Req,
  input  wire logic        dma2Ack,
  output logic [31:0]      dma2Data
);

  // -----------------------------------------------------------------------
  // Register file.
  // -----------------------------------------------------------------------
  logic [2:0]  cfg_r;
  logic [1:0]  lineSel_r;
  logic        ch0On_r, ch2On_r, overrun_r, ovrSet, errAcc_r;
  logic [63:0] dither_r;
  logic [7:0]  bgConst_r, bgPeak_r, compVid_r, corrCur_r;
  logic [15:0] lineNum_r;
  logic        activeWin;
  logic        wrEn, setupRd;
  logic [31:0] rdMux;
  logic        mapped;

  assign wrEn    = psel && penable && pwrite;
  assign setupRd = psel && !penable;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && errAcc_r;

  // Decode is combinational; read data is latched in the setup cycle.
  always_comb begin
    rdMux  = 32'h0;
    mapped = 1'b1;
    case (paddr)
      cisc_pkg::OFF_CFG:       rdMux = {29'h0, cfg_r};
      cisc_pkg::OFF_LINE_SEL:  rdMux = {30'h0, lineSel_r};
      cisc_pkg::OFF_CH0_CTRL:  rdMux = {31'h0, ch0On_r};
      cisc_pkg::OFF_CH2_CTRL:  rdMux = {31'h0, ch2On_r};
      cisc_pkg::OFF_DITHER_LO: rdMux = dither_r[31:0];
      cisc_pkg::OFF_DITHER_HI: rdMux = dither_r[63:32];
      cisc_pkg::OFF_BG_CONST:  rdMux = {24'h0, bgConst_r};
      cisc_pkg::OFF_STATUS: begin
        rdMux[cisc_pkg::ST_AVW_BIT] = activeWin;
        rdMux[cisc_pkg::ST_PDW_BIT] = peakWindow;
        rdMux[cisc_pkg::ST_OVR_BIT] = overrun_r;
        rdMux[cisc_pkg::ST_BG_LSB +: 8] = bgPeak_r;
        rdMux[cisc_pkg::ST_LINE_LSB +: 16] = lineNum_r;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata   <= 32'h0;
      errAcc_r <= 1'b0;
    end else if (setupRd) begin
      prdata   <= pwrite ? 32'h0 : rdMux;
      errAcc_r <= !mapped;
    end
  end

  // Software-written control registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_r     <= 3'h0;
      lineSel_r <= 2'h0;
      ch0On_r   <= 1'b0;
      ch2On_r   <= 1'b0;
      dither_r  <= {cisc_pkg::DITHER_RST, cisc_pkg::DITHER_RST};
      bgConst_r <= cisc_pkg::BG_RST;
    end else if (wrEn) begin
      case (paddr)
        cisc_pkg::OFF_CFG:       cfg_r     <= pwdata[2:0];
        cisc_pkg::OFF_LINE_SEL:  lineSel_r <= pwdata[1:0];
        cisc_pkg::OFF_CH0_CTRL:  ch0On_r   <= pwdata[cisc_pkg::CHAN_ON_BIT];
        cisc_pkg::OFF_CH2_CTRL:  ch2On_r   <= pwdata[cisc_pkg::CHAN_ON_BIT];
        cisc_pkg::OFF_DITHER_LO: dither_r[31:0]  <= pwdata;
        cisc_pkg::OFF_DITHER_HI: dither_r[63:32] <= pwdata;
        cisc_pkg::OFF_BG_CONST:  bgConst_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Overrun flag: write one to clear, a new overrun in the same cycle wins.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) overrun_r <= 1'b0;
    else if (ovrSet) overrun_r <= 1'b1;
    else if (wrEn && paddr == cisc_pkg::OFF_STATUS && pwdata[cisc_pkg::ST_OVR_BIT])
      overrun_r <= 1'b0;
  end

  // -----------------------------------------------------------------------
  // Line and pixel timing generator.
  // -----------------------------------------------------------------------
  logic        scanRun;
  logic [19:0] lineCnt_r, lineLen;
  logic [6:0]  phase_r, halfPh;
  logic [10:0] pixIdx_r;
  logic        pixRun_r, pixEnd, pixMore, lineEnd;

  assign scanRun = cfg_r[cisc_pkg::CFG_SCAN_BIT];
  assign lineLen = 20'(LINE_BASE_CYC) << lineSel_r; // [RQ2]
  // A shorter line select must not strand the counter past the new line end.
  assign lineEnd = lineCnt_r >= lineLen - 20'd1;
  assign pixEnd  = pixRun_r && phase_r == 7'(cisc_pkg::PIX_CYC - 1);
  assign halfPh  = (phase_r >= 7'(cisc_pkg::HALF_CYC)) ? phase_r - 7'(cisc_pkg::HALF_CYC)
                                                       : phase_r;
  // A new pixel starts only if it ends a guard gap before the next line start.
  assign pixMore = pixIdx_r < 11'(cisc_pkg::PIX_TOTAL - 1) &&
                   lineCnt_r + 20'(cisc_pkg::PIX_CYC + cisc_pkg::SEP_CYC) < lineLen; // [RQ17]

  // Line counter, pixel phase and pixel index.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lineCnt_r <= 20'h0;
      phase_r   <= 7'h0;
      pixIdx_r  <= 11'h0;
      pixRun_r  <= 1'b0;
      lineNum_r <= 16'h0;
    end else if (!scanRun) begin
      lineCnt_r <= 20'h0; // [RQ18]
      phase_r   <= 7'h0;
      pixIdx_r  <= 11'h0;
      pixRun_r  <= 1'b0;
    end else begin
      lineCnt_r <= lineEnd ? 20'h0 : lineCnt_r + 20'd1;
      if (lineEnd) lineNum_r <= lineNum_r + 16'd1;
      if (!pixRun_r && lineCnt_r == 20'(cisc_pkg::PIX_START - 1)) begin
        pixRun_r <= 1'b1;
        pixIdx_r <= 11'h0;
        phase_r  <= 7'h0;
      end else if (pixRun_r) begin
        phase_r <= pixEnd ? 7'h0 : phase_r + 7'd1;
        if (pixEnd) begin
          pixRun_r <= pixMore; // [RQ15]
          pixIdx_r <= pixIdx_r + 11'd1;
        end
      end
    end
  end

  assign activeWin = pixRun_r;

  // Strobe outputs, all registered with the same single cycle of lag.
  // Pixel timing stops low, so the line start pulse never meets its edges.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sensorShiftTiming <= 1'b0;
      outputResetStrobe <= 1'b0;
      sampleHoldStrobe  <= 1'b0;
      lineStartPulse    <= 1'b0;
      peakWindow        <= 1'b0;
    end else begin
      sensorShiftTiming <= scanRun && pixRun_r && phase_r < 7'(cisc_pkg::HALF_CYC); // [RQ1]
      outputResetStrobe <= scanRun && pixRun_r &&
                           halfPh >= 7'(cisc_pkg::DIS_DLY_CYC); // [RQ14] [RQ16]
      sampleHoldStrobe  <= scanRun && pixRun_r && halfPh >= 7'(cisc_pkg::SNH_DLY_CYC) &&
                           halfPh < 7'(cisc_pkg::SNH_DLY_CYC + cisc_pkg::SNH_W_CYC); // [RQ16]
      lineStartPulse    <= scanRun && lineCnt_r >= 20'(cisc_pkg::LS_LEAD) &&
                           lineCnt_r < 20'(cisc_pkg::LS_LEAD + cisc_pkg::LS_CYC); // [RQ13]
      peakWindow        <= scanRun && pixRun_r && pixIdx_r >= 11'(cisc_pkg::PDW_FIRST) &&
                           pixIdx_r < 11'(cisc_pkg::PDW_FIRST + cisc_pkg::PDW_LEN); // [RQ4] [RQ19]
    end
  end

  // -----------------------------------------------------------------------
  // Channel 0: double-buffered correction bytes.
  // -----------------------------------------------------------------------
  logic        ch0Go, firstDone_r, snhEvt;
  logic [15:0] corrBuf_r;
  logic [1:0]  corrCnt_r;

  assign ch0Go  = cfg_r[cisc_pkg::CFG_CH0_SEL_BIT] && ch0On_r;
  assign snhEvt = scanRun && pixRun_r && halfPh == 7'(cisc_pkg::SNH_DLY_CYC);

  // The first fill runs at once; refills wait for the active window.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma0Req     <= 1'b0;
      firstDone_r <= 1'b0;
      corrBuf_r   <= 16'h0;
      corrCnt_r   <= 2'h0;
      corrCur_r   <= 8'h0;
    end else if (!ch0Go) begin
      dma0Req     <= 1'b0;
      firstDone_r <= 1'b0;
      corrCnt_r   <= 2'h0;
    end else begin
      if (dma0Req && dma0Ack) begin
        dma0Req     <= 1'b0;
        corrBuf_r   <= dma0Data;
        corrCnt_r   <= 2'd2;
        firstDone_r <= 1'b1;
      end else if (!dma0Req && corrCnt_r == 2'd0 && (!firstDone_r || activeWin)) begin
        dma0Req <= 1'b1; // [RQ5] [RQ3]
      end
      if (snhEvt && corrCnt_r != 2'd0) begin
        corrCur_r <= (corrCnt_r == 2'd2) ? corrBuf_r[7:0] : corrBuf_r[15:8]; // [RQ6]
        corrCnt_r <= corrCnt_r - 2'd1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Video sample crossing from the link clock.
  // -----------------------------------------------------------------------
  logic [1:0] linkRst_r;
  logic       linkTog_r;
  logic [7:0] linkHold_r;
  logic       togS1_r, togS2_r, togS3_r, newPix;

  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) linkRst_r <= 2'b00;
    else linkRst_r <= {linkRst_r[0], 1'b1};
  end

  // Data is held stable while the toggle crosses; samples come far slower.
  always_ff @(posedge linkClk or negedge linkRst_r[1]) begin
    if (!linkRst_r[1]) begin
      linkTog_r  <= 1'b0;
      linkHold_r <= 8'h0;
    end else if (videoStrobe) begin
      linkTog_r  <= ~linkTog_r;
      linkHold_r <= videoInputLevel;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) {togS3_r, togS2_r, togS1_r} <= 3'b000;
    else {togS3_r, togS2_r, togS1_r} <= {togS2_r, togS1_r, linkTog_r};
  end
  assign newPix = togS2_r ^ togS3_r;

  // -----------------------------------------------------------------------
  // Compensation, background, threshold, comparison and packing.
  // -----------------------------------------------------------------------
  logic [8:0]  compSum;
  logic        compValid_r, darkBit;
  logic [7:0]  bgLevel, ditherByte, threshold;
  logic [15:0] thrProd;
  logic [10:0] samp_r;
  logic [31:0] shift_r;
  logic [4:0]  shiftCnt_r;
  logic        lsSeen_r;

  assign compSum    = {1'b0, linkHold_r} + {1'b0, corrCur_r};
  assign bgLevel    = cfg_r[cisc_pkg::CFG_GRAY_BIT] ? bgConst_r : bgPeak_r; // [RQ9] [RQ10]
  assign ditherByte = dither_r[8*samp_r[2:0] +: 8];
  assign thrProd    = ditherByte * bgLevel; // [RQ8]
  assign threshold  = thrProd[15:8];
  assign darkBit    = compVid_r < threshold; // [RQ11]

  // Stage one: saturated compensated level of the new sample.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      compVid_r   <= 8'h0;
      compValid_r <= 1'b0;
    end else begin
      compValid_r <= newPix;
      if (newPix) compVid_r <= compSum[8] ? 8'hff : compSum[7:0]; // [RQ7]
    end
  end

  // Background tracker follows the peak inside the window, restarting per line.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bgPeak_r <= 8'h0;
      lsSeen_r <= 1'b0;
      samp_r   <= 11'h0;
    end else begin
      lsSeen_r <= lineStartPulse;
      if (lineStartPulse && !lsSeen_r) begin
        bgPeak_r <= 8'h0;
        samp_r   <= 11'h0;
      end else if (compValid_r) begin
        samp_r <= samp_r + 11'd1;
        if (peakWindow && compVid_r > bgPeak_r) bgPeak_r <= compVid_r; // [RQ7]
      end
    end
  end

  // Shift register and output word; a late acknowledge loses the new word.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift_r    <= 32'h0;
      shiftCnt_r <= 5'h0;
      dma2Req    <= 1'b0;
      dma2Data   <= 32'h0;
      ovrSet     <= 1'b0;
    end else begin
      ovrSet <= 1'b0;
      if (dma2Req && dma2Ack) dma2Req <= 1'b0;
      if (compValid_r) begin
        shift_r    <= {shift_r[30:0], darkBit}; // [RQ11]
        shiftCnt_r <= shiftCnt_r + 5'd1;
        if (shiftCnt_r == 5'd31 && ch2On_r) begin
          if (dma2Req && !dma2Ack) ovrSet <= 1'b1;
          else begin
            dma2Data <= {shift_r[30:0], darkBit}; // [RQ12]
            dma2Req  <= 1'b1;
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Assertions and helpers.
  // -----------------------------------------------------------------------
  localparam int PIXC = cisc_pkg::PIX_CYC;
  logic [7:0] lsRun_r, disRun_r, sinceCl_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lsRun_r   <= 8'h0;
      disRun_r  <= 8'h0;
      sinceCl_r <= 8'hff;
    end else begin
      lsRun_r   <= lineStartPulse ? lsRun_r + 8'd1 : 8'h0;
      disRun_r  <= outputResetStrobe ? disRun_r + 8'd1 : 8'h0;
      if ($changed(sensorShiftTiming)) sinceCl_r <= 8'h1;
      else if (sinceCl_r != 8'hff) sinceCl_r <= sinceCl_r + 8'd1;
    end
  end

  property p_stop;
    @(posedge mclk) disable iff (!resetn)
      !scanRun |=> !sensorShiftTiming && !lineStartPulse && !sampleHoldStrobe &&
                   !outputResetStrobe && !peakWindow;
  endproperty
  a_stop: assert property (p_stop) else $error("strobe active without scan-run"); // [RQ18]

  property p_ls_width;
    @(posedge mclk) disable iff (!resetn)
      $fell(lineStartPulse) |-> lsRun_r >= 8'(cisc_pkg::LS_CYC);
  endproperty
  a_ls_width: assert property (p_ls_width) else $error("line start too short"); // [RQ13]

  property p_dis_delay;
    @(posedge mclk) disable iff (!resetn)
      $rose(outputResetStrobe) |-> sinceCl_r >= 8'(cisc_pkg::DIS_DLY_CYC);
  endproperty
  a_dis_delay: assert property (p_dis_delay) else $error("reset strobe too early"); // [RQ14]

  property p_dis_width;
    @(posedge mclk) disable iff (!resetn)
      $fell(outputResetStrobe) |-> disRun_r >= 8'(cisc_pkg::DIS_W_CYC);
  endproperty
  a_dis_width: assert property (p_dis_width) else $error("reset strobe too short"); // [RQ14]

  property p_ls_sep;
    @(posedge mclk) disable iff (!resetn)
      $changed(lineStartPulse) |-> sinceCl_r >= 8'(cisc_pkg::SEP_CYC);
  endproperty
  a_ls_sep: assert property (p_ls_sep) else $error("line start edge near pixel edge"); // [RQ15]

  property p_pix_rate;
    @(posedge mclk) disable iff (!resetn)
      $rose(sensorShiftTiming) |-> ##PIXC ($rose(sensorShiftTiming) || !sensorShiftTiming);
  endproperty
  a_pix_rate: assert property (p_pix_rate) else $error("pixel period wrong"); // [RQ16]

  property p_peak_inside;
    @(posedge mclk) disable iff (!resetn)
      peakWindow |-> $past(activeWin);
  endproperty
  a_peak_inside: assert property (p_peak_inside) else $error("peak outside window"); // [RQ4]

  property p_ch0_start;
    @(posedge mclk) disable iff (!resetn)
      $rose(ch0Go) |-> ##[1:2] dma0Req;
  endproperty
  a_ch0_start: assert property (p_ch0_start) else $error("no first fetch"); // [RQ5]

  property p_ch2_word;
    @(posedge mclk) disable iff (!resetn)
      compValid_r && shiftCnt_r == 5'd31 && ch2On_r && !dma2Req |=>
        dma2Req && dma2Data[0] == $past(darkBit);
  endproperty
  a_ch2_word: assert property (p_ch2_word) else $error("full word not offered"); // [RQ12]

  c_line: cover property (@(posedge mclk) disable iff (!resetn) $fell(lineStartPulse));
  c_peak: cover property (@(posedge mclk) disable iff (!resetn) $rose(peakWindow));
  c_ch0:  cover property (@(posedge mclk) disable iff (!resetn) dma0Req && dma0Ack);
  c_ch2:  cover property (@(posedge mclk) disable iff (!resetn) dma2Req && dma2Ack);

endmodule : cisc_scan_ctrl

// ===== tb/cisc_sensor_model.sv
// Sample-and-hold converter model that answers the controller on the video link.
`timescale 1ns/1ps
module cisc_sensor_model (
  // Link clock and reset.
  input  wire logic       linkClk,
  input  wire logic       resetn,
  // Strobe from the controller and analog level set by the bench.
  input  wire logic       sampleHoldStrobe,
  input  wire logic [7:0] level,
  // Held sample towards the controller.
  output logic            videoStrobe,
  output logic [7:0]      videoInputLevel
);
  logic [2:0] shSync;

  // The strobe is resynchronised, so each sample lands a few link cycles after its edge.
  // Between samples the level toggles, so a late read never sees a stale match.
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      shSync          <= 3'h0;
      videoStrobe     <= 1'b0;
      videoInputLevel <= 8'h00;
    end else begin
      shSync          <= {shSync[1:0], sampleHoldStrobe};
      videoStrobe     <= shSync[1] && !shSync[2];
      videoInputLevel <= (shSync[1] && !shSync[2]) ? level : ~videoInputLevel;
    end
  end
endmodule : cisc_sensor_model

// ===== tb/cisc_scan_ctrl_tb.sv
// Testbench of the scan controller: strobe timing, fetch, dithering and packing.
`timescale 1ns/1ps
module cisc_tb_meter (
  // Watched signal and its reference.
  input  wire logic clk,
  input  wire logic sig,
  input  wire logic refSig,
  // Last high width, rise-to-rise period, rise delay after a reference edge.
  output int        w,
  output int        p,
  output int        d
);
  logic sQ;
  logic rQ;
  int   hi;
  int   sr;
  int   se;

  // Counts in whole mclk cycles between sampled edges.
  always @(posedge clk) begin
    sQ <= sig;
    rQ <= refSig;
    hi <= sig ? hi + 1 : 0;
    sr <= (sig && !sQ) ? 1 : sr + 1;
    se <= (refSig != rQ) ? 1 : se + 1;
    if (!sig && sQ) w <= hi;
    if (sig && !sQ) begin
      p <= sr;
      d <= se;
    end
  end
endmodule : cisc_tb_meter

module cisc_scan_ctrl_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int          LB   = 400;
  localparam logic [31:0] SCAN = 32'h1 << cisc_pkg::CFG_SCAN_BIT;
  localparam logic [31:0] SEL  = 32'h1 << cisc_pkg::CFG_CH0_SEL_BIT;
  localparam logic [31:0] GRAY = 32'h1 << cisc_pkg::CFG_GRAY_BIT;
  logic        mclk = 0, linkClk = 0, resetn = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0]  paddr = 8'h00, videoInputLevel, lvl = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, dma2Data, lastWord;
  logic        sh, rs, ls, pk, cl, videoStrobe;
  logic        dma0Req, dma0Ack = 0, dma2Req, dma2Ack = 0;
  logic [15:0] dma0Data = 16'h0000;
  int          error_cnt = 0, n_checks = 0, nWords = 0, n0 = 0;
  int          lsW, lsP, lsD, clW, clP, clD, rsW, rsP, rsD, shW, shP, shD;

  cisc_scan_ctrl #(.LINE_BASE_CYC(LB)) dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sampleHoldStrobe(sh), .outputResetStrobe(rs),
    .lineStartPulse(ls), .peakWindow(pk), .sensorShiftTiming(cl), .linkClk, .videoStrobe,
    .videoInputLevel, .dma0Req, .dma0Ack, .dma0Data, .dma2Req, .dma2Ack, .dma2Data);
  cisc_sensor_model partner (.linkClk, .resetn, .sampleHoldStrobe(sh), .level(lvl),
    .videoStrobe, .videoInputLevel);
  cisc_tb_meter mLs (.clk(mclk), .sig(ls), .refSig(cl), .w(lsW), .p(lsP), .d(lsD));
  cisc_tb_meter mCl (.clk(mclk), .sig(cl), .refSig(ls), .w(clW), .p(clP), .d(clD));
  cisc_tb_meter mRs (.clk(mclk), .sig(rs), .refSig(cl), .w(rsW), .p(rsP), .d(rsD));
  cisc_tb_meter mSh (.clk(mclk), .sig(sh), .refSig(cl), .w(shW), .p(shP), .d(shD));

  // Clocks of unrelated phase.
  initial forever #25 mclk = ~mclk;
  initial begin
    #2.3;
    forever #3 linkClk = ~linkClk;
  end

  // Memory side of both channels: acknowledge at once, keep the latest packed word.
  always @(posedge mclk) begin
    dma0Ack <= dma0Req && !dma0Ack;
    dma2Ack <= dma2Req && !dma2Ack;
    if (dma0Ack && dma0Req) n0 <= n0 + 1;
    if (dma2Ack && dma2Req) begin
      lastWord <= dma2Data;
      nWords   <= nWords + 1;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; answer data is taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, expErr});
  endtask : rd

  // Skip words that may straddle a setting change, then check a whole new one.
  task automatic words(input logic [31:0] exp);
    int w0;
    w0 = nWords;
    wait (nWords >= w0 + 3);
    chk(lastWord, exp);
  endtask : words

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  // Watchdog at 80k cycles, well past the expected run of some 38k cycles.
  initial begin
    #4000000;
    error_cnt++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(cisc_pkg::OFF_CFG, 32'h0, 1'b0);
    rd(cisc_pkg::OFF_DITHER_LO, cisc_pkg::DITHER_RST, 1'b0);
    rd(cisc_pkg::OFF_DITHER_HI, cisc_pkg::DITHER_RST, 1'b0);
    rd(cisc_pkg::OFF_BG_CONST, {24'h0, cisc_pkg::BG_RST}, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(cisc_pkg::OFF_CFG, SEL);
    repeat (4) @(posedge mclk);
    chk(n0, 0);
    wr(cisc_pkg::OFF_CH0_CTRL, 32'h1 << cisc_pkg::CHAN_ON_BIT);
    repeat (4) @(posedge mclk);
    chk(n0, 1);
    wr(cisc_pkg::OFF_CH2_CTRL, 32'h1 << cisc_pkg::CHAN_ON_BIT);
    wr(cisc_pkg::OFF_LINE_SEL, 32'h3);
    lvl <= 8'h40;
    wr(cisc_pkg::OFF_CFG, SEL | SCAN);
    words(32'h00000000);
    wr(cisc_pkg::OFF_CFG, SEL | SCAN | GRAY);
    words(32'hffffffff);
    // A correction of 0x40 lifts the level to 0x80, above the gray threshold of 0x7f.
    dma0Data <= 16'h4040;
    words(32'h00000000);
    // Full-scale dither bytes raise the threshold to 0xfe, so every pixel is dark again.
    wr(cisc_pkg::OFF_DITHER_LO, 32'hffffffff);
    wr(cisc_pkg::OFF_DITHER_HI, 32'hffffffff);
    words(32'hffffffff);
    @(negedge ls);
    repeat (600) @(posedge mclk);
    chk(lsW * cisc_pkg::MCLK_NS >= cisc_pkg::LS_MIN_NS, 1);
    chk(lsD * cisc_pkg::MCLK_NS >= 800, 1);
    chk(clD * cisc_pkg::MCLK_NS >= 800, 1);
    chk(rsW * cisc_pkg::MCLK_NS >= 625, 1);
    chk(rsD * cisc_pkg::MCLK_NS >= 1875, 1);
    chk(shP, clW);
    chk(rsP, clW);
    // The line select changes only while stopped, and each stop waits for the end of the
    // line start pulse, before any pixel starts, so that no strobe is cut short.
    for (int s = 0; s < 4; s++) begin
      @(negedge ls);
      wr(cisc_pkg::OFF_CFG, SEL);
      wr(cisc_pkg::OFF_LINE_SEL, s);
      wr(cisc_pkg::OFF_CFG, SEL | SCAN);
      repeat (3) @(posedge ls);
      chk(lsP, LB << s);
    end
    @(negedge ls);
    wr(cisc_pkg::OFF_CFG, SEL);
    repeat (4) @(posedge mclk);
    chk({sh, rs, ls, pk, cl}, 0);
    repeat (500) @(posedge mclk);
    chk({sh, rs, ls, pk, cl}, 0);
    complete_run();
  end
endmodule : cisc_scan_ctrl_tb
